/* File: src/watchdog_reload_lock.sv */
`timescale 1ns/100ps

// Notes on behaviour
// - Write 55H then AAH to unlock reloads
// - Key writes leave status bits unchanged
// - Stray write returns lock to start
// - Load counter on enable and refresh
// - Status flags read-only; read clears bits 7-4
// - Reset cause sets matching flag pattern
// - Stop recovery sets stop; timeout per cause
// - Power-on flag set and cleared rules
// - Stop flag cleared by POR, timeout outside STOP, read
// - Timeout flag set on any timeout
// - External flag set by reset pin
// - Reserved status bits read zero
// - Stop bit halts watchdog in STOP
// - Reload is upper, high, low bytes
// - Permitted reload writes update value
// - Reload reads return live count
// - Timeout outside STOP resets device
// - Timeout in STOP starts stop recovery
// - Keys then 81H sets, 00H clears
module watchdog_reload_lock (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wdt_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [wdt_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [wdt_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic osc_tick,
    input wire logic refresh_insn,
    input wire logic stop_mode,
    input wire logic ext_reset_event,
    input wire logic debug_reset_event,
    input wire logic dbg_pin_stop_reset,
    input wire logic gpio_stop_recovery,
    output logic device_reset_req,
    output logic stop_recovery_req,
    output logic osc_run
);

    import wdt_pkg::*;

    // Bus state
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [DATA_W-1:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;

    // Watchdog state
    unlock_state_type state_r, state_nxt;
    logic stop_cfg_r, stop_cfg_nxt;
    logic enable_r, rst_cfg_r;
    logic por_r, stop_r, wdt_r, ext_r;
    logic por_nxt, stop_nxt, wdt_nxt, ext_nxt;
    logic [COUNT_W-1:0] count_r, count_nxt;
    logic dev_rst_r, stop_rec_r, osc_run_r;
    logic ld_upper, ld_high, ld_low;

    // Handshakes and write decode
    wire aw_hs = awvalid && awready_r;
    wire w_hs = wvalid && wready_r;
    wire ar_hs = arvalid && arready_r;
    wire wr_go = !awready_r && !wready_r && !bvalid_r;
    wire wr_lane = wr_go && w_strb_r[0];
    wire [BYTE_W-1:0] wr_byte = w_data_r[BYTE_W-1:0];

    wire wa_status = aw_addr_r == OFF_STATUS_CONTROL;
    wire wa_upper = aw_addr_r == OFF_RELOAD_UPPER;
    wire wa_high = aw_addr_r == OFF_RELOAD_HIGH;
    wire wa_low = aw_addr_r == OFF_RELOAD_LOW;
    wire wa_ctrl = aw_addr_r == OFF_WDT_CONTROL;
    wire wa_map = wa_status || wa_upper || wa_high || wa_low || wa_ctrl;

    wire wr_status = wr_lane && wa_status;
    wire wr_upper = wr_lane && wa_upper;
    wire wr_high = wr_lane && wa_high;
    wire wr_low = wr_lane && wa_low;
    wire wr_ctrl = wr_lane && wa_ctrl;
    wire wr_key1 = wr_status && (wr_byte == KEY_FIRST);

    // Read decode
    wire ra_status = araddr == OFF_STATUS_CONTROL;
    wire ra_upper = araddr == OFF_RELOAD_UPPER;
    wire ra_high = araddr == OFF_RELOAD_HIGH;
    wire ra_low = araddr == OFF_RELOAD_LOW;
    wire ra_ctrl = araddr == OFF_WDT_CONTROL;
    wire ra_map = ra_status || ra_upper || ra_high || ra_low || ra_ctrl;
    wire status_read = ar_hs && ra_status;

    wire [BYTE_W-1:0] status_byte = {por_r, stop_r, wdt_r, ext_r,
                                     RSVD_ZERO, stop_cfg_r};
    wire [DATA_W-1:0] ctrl_word = {CTL_PAD_ZERO, rst_cfg_r, enable_r};
    wire [DATA_W-1:0] rd_word =
        ra_status ? {PAD_ZERO, status_byte} :
        ra_upper ? {PAD_ZERO, count_r[COUNT_W-1 -: BYTE_W]} :
        ra_high ? {PAD_ZERO, count_r[2*BYTE_W-1 -: BYTE_W]} :
        ra_low ? {PAD_ZERO, count_r[BYTE_W-1:0]} :
        ra_ctrl ? ctrl_word : '0;

    // Reload value and counter control
    logic [BYTE_W-1:0] rl_upper;
    logic [BYTE_W-1:0] rl_high;
    logic [BYTE_W-1:0] rl_low;
    wire [COUNT_W-1:0] reload_value = {rl_upper, rl_high, rl_low};

    wire en_load = wr_ctrl && wr_byte[CTL_ENABLE_BIT] && !enable_r;
    wire refresh = refresh_insn || (wr_ctrl && wr_byte[CTL_REFRESH_BIT]);
    wire halted = stop_mode && stop_cfg_r;
    wire running = enable_r && !halted;
    wire timeout = osc_tick && running && (count_r == COUNT_RESET);

    reload_byte #(.WIDTH(BYTE_W), .RESET_VAL(RELOAD_BYTE_RESET)) u_upper (
        .aclk(aclk), .aresetn(aresetn), .load(ld_upper), .din(wr_byte),
        .q(rl_upper)
    );

    reload_byte #(.WIDTH(BYTE_W), .RESET_VAL(RELOAD_BYTE_RESET)) u_high (
        .aclk(aclk), .aresetn(aresetn), .load(ld_high), .din(wr_byte),
        .q(rl_high)
    );

    reload_byte #(.WIDTH(BYTE_W), .RESET_VAL(RELOAD_BYTE_RESET)) u_low (
        .aclk(aclk), .aresetn(aresetn), .load(ld_low), .din(wr_byte),
        .q(rl_low)
    );

    // Unlock sequencer; only key steps touch the stop bit
    always_comb begin
        state_nxt = state_r;
        stop_cfg_nxt = stop_cfg_r;
        ld_upper = 1'b0;
        ld_high = 1'b0;
        ld_low = 1'b0;
        if (wr_lane) begin
            state_nxt = UNLOCK_IDLE;
            case (state_r)
                UNLOCK_IDLE: begin
                    state_nxt = UNLOCK_IDLE;
                end
                UNLOCK_KEY1: begin
                    if (wr_status && wr_byte == KEY_SECOND) begin
                        state_nxt = UNLOCK_KEY2;
                    end
                end
                UNLOCK_KEY2: begin
                    if (wr_upper) begin
                        ld_upper = 1'b1;
                        state_nxt = UNLOCK_UPPER;
                    end else if (wr_status && wr_byte == STOP_OFF_CODE) begin
                        stop_cfg_nxt = 1'b1;
                    end else if (wr_status && wr_byte == STOP_ON_CODE) begin
                        stop_cfg_nxt = 1'b0;
                    end
                end
                UNLOCK_UPPER: begin
                    if (wr_high) begin
                        ld_high = 1'b1;
                        state_nxt = UNLOCK_HIGH;
                    end
                end
                UNLOCK_HIGH: begin
                    if (wr_low) begin
                        ld_low = 1'b1;
                        state_nxt = UNLOCK_IDLE;
                    end
                end
                default: begin
                    state_nxt = UNLOCK_IDLE;
                end
            endcase
            if (wr_key1) begin
                state_nxt = UNLOCK_KEY1;
            end
        end
    end

    // Cause flags: read clears first, events then win
    always_comb begin
        por_nxt = por_r;
        stop_nxt = stop_r;
        wdt_nxt = wdt_r;
        ext_nxt = ext_r;
        if (status_read) begin
            por_nxt = 1'b0;
            stop_nxt = 1'b0;
            wdt_nxt = 1'b0;
            ext_nxt = 1'b0;
        end
        if (ext_reset_event) begin
            por_nxt = 1'b0;
            stop_nxt = 1'b0;
            wdt_nxt = 1'b0;
            ext_nxt = 1'b1;
        end
        if (debug_reset_event || dbg_pin_stop_reset) begin
            por_nxt = 1'b1;
            stop_nxt = 1'b0;
            wdt_nxt = 1'b0;
            ext_nxt = 1'b0;
        end
        if (gpio_stop_recovery) begin
            por_nxt = 1'b0;
            stop_nxt = 1'b1;
            wdt_nxt = 1'b0;
            ext_nxt = 1'b0;
        end
        if (timeout) begin
            por_nxt = 1'b0;
            wdt_nxt = 1'b1;
            stop_nxt = stop_mode;
        end
    end

    // Counter load and count down
    always_comb begin
        count_nxt = count_r;
        if (en_load || refresh || timeout) begin
            count_nxt = reload_value;
        end else if (osc_tick && running) begin
            count_nxt = count_r - COUNT_ONE;
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else begin
            if (aw_hs) begin
                awready_r <= 1'b0;
                aw_addr_r <= awaddr;
            end
            if (w_hs) begin
                wready_r <= 1'b0;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wa_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else begin
            if (ar_hs) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= ra_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid_r && rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // Lock, configuration and flags; bus reset acts as power-on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= UNLOCK_IDLE;
            stop_cfg_r <= 1'b0;
            por_r <= 1'b1;
            stop_r <= 1'b0;
            wdt_r <= 1'b0;
            ext_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            stop_cfg_r <= stop_cfg_nxt;
            por_r <= por_nxt;
            stop_r <= stop_nxt;
            wdt_r <= wdt_nxt;
            ext_r <= ext_nxt;
        end
    end

    // Enable, action on timeout, counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r <= 1'b0;
            rst_cfg_r <= 1'b0;
            count_r <= COUNT_RESET;
        end else begin
            if (wr_ctrl) begin
                enable_r <= wr_byte[CTL_ENABLE_BIT];
                rst_cfg_r <= wr_byte[CTL_RESET_CFG_BIT];
            end
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dev_rst_r <= 1'b0;
            stop_rec_r <= 1'b0;
            osc_run_r <= 1'b1;
        end else begin
            dev_rst_r <= timeout && rst_cfg_r && !stop_mode;
            stop_rec_r <= timeout && rst_cfg_r && stop_mode;
            osc_run_r <= !halted;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign device_reset_req = dev_rst_r;
    assign stop_recovery_req = stop_rec_r;
    assign osc_run = osc_run_r;

endmodule

/* File: src/wdt_pkg.sv */
package wdt_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int PAD_W = DATA_W - BYTE_W;
    localparam int COUNT_W = 24;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 12'hFF0;
    localparam logic [ADDR_W-1:0] OFF_RELOAD_UPPER = 12'hFF4;
    localparam logic [ADDR_W-1:0] OFF_RELOAD_HIGH = 12'hFF8;
    localparam logic [ADDR_W-1:0] OFF_RELOAD_LOW = 12'hFFC;
    localparam logic [ADDR_W-1:0] OFF_WDT_CONTROL = 12'hFE0;

    // Unlock and stop-configuration keys
    localparam logic [BYTE_W-1:0] KEY_FIRST = 8'h55;
    localparam logic [BYTE_W-1:0] KEY_SECOND = 8'hAA;
    localparam logic [BYTE_W-1:0] STOP_OFF_CODE = 8'h81;
    localparam logic [BYTE_W-1:0] STOP_ON_CODE = 8'h00;

    // Own control register fields
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_RESET_CFG_BIT = 1;
    localparam int CTL_REFRESH_BIT = 2;

    // Reset values
    localparam logic [BYTE_W-1:0] RELOAD_BYTE_RESET = 8'hFF;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
    localparam logic [2:0] RSVD_ZERO = 3'h0;
    localparam logic [PAD_W-1:0] PAD_ZERO = 24'h000000;
    localparam logic [DATA_W-3:0] CTL_PAD_ZERO = 30'h0000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        UNLOCK_IDLE,
        UNLOCK_KEY1,
        UNLOCK_KEY2,
        UNLOCK_UPPER,
        UNLOCK_HIGH
    } unlock_state_type;

endpackage

/* File: src/reload_byte.sv */
`timescale 1ns/100ps

// One byte of the stored reload value
module reload_byte #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= RESET_VAL;
        end else if (load) begin
            q_r <= din;
        end
    end

    assign q = q_r;

endmodule

/* File: testbench/watchdog_reload_lock_checker.sv */
`timescale 1ns/100ps

module watchdog_reload_lock_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wdt_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [wdt_pkg::DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic osc_tick,
    input wire logic stop_mode,
    input wire logic device_reset_req,
    input wire logic stop_recovery_req,
    input wire logic osc_run
);
    import wdt_pkg::*;
    logic [ADDR_W-1:0] rd_addr_r;

    // Address of the read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rd_addr_r <= '0;
        else if (arvalid && arready)
            rd_addr_r <= araddr;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_R_LAT: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    AST_RSVD_ZERO: assert property (
        rvalid && rd_addr_r == OFF_STATUS_CONTROL
        |-> rdata[3:1] == RSVD_ZERO && rdata[31:8] == PAD_ZERO)
        else $error("reserved status bits set");
    AST_OSC_RUN: assert property (!stop_mode |=> osc_run)
        else $error("oscillator stopped outside stop");
    AST_OSC_FALL: assert property (
        $fell(osc_run) |-> $past(stop_mode))
        else $error("oscillator fell without stop");
    AST_RST_CAUSE: assert property (
        device_reset_req |-> !$past(stop_mode)
        && ($past(osc_tick) || $past(osc_tick, 2)))
        else $error("reset request without tick outside stop");
    AST_SMR_CAUSE: assert property (
        stop_recovery_req |-> $past(stop_mode)
        && ($past(osc_tick) || $past(osc_tick, 2)))
        else $error("recovery request without tick in stop");
    AST_REQ_EXCL: assert property (
        !(device_reset_req && stop_recovery_req))
        else $error("both timeout requests at once");
endmodule

bind watchdog_reload_lock watchdog_reload_lock_checker watch_i (.aclk,
    .aresetn, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready,
    .osc_tick, .stop_mode, .device_reset_req, .stop_recovery_req, .osc_run);

/* File: testbench/watchdog_reload_lock_tb.sv */
`timescale 1ns/100ps

module watchdog_reload_lock_tb;
    import wdt_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 0;
    logic wvalid = 0;
    logic bready = 0;
    logic arvalid = 0;
    logic rready = 0;
    logic stop_mode = 0;
    logic [5:0] ev = '0;
    logic awready, wready, bvalid, arready, rvalid, osc_run;
    logic device_reset_req, stop_recovery_req;
    logic [1:0] bresp, rresp, rsp;
    logic [DATA_W-1:0] rdata, d;
    logic [23:0] val;
    int fails = 0;
    int total_checks = 0;
    int rst_seen = 0;
    int smr_seen = 0;
    int k;

    always #25 aclk = ~aclk;

    always @(posedge aclk) begin
        if (device_reset_req === 1'b1)
            rst_seen++;
        if (stop_recovery_req === 1'b1)
            smr_seen++;
    end

    watchdog_reload_lock dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .osc_tick(ev[0]),
        .refresh_insn(ev[1]), .stop_mode, .ext_reset_event(ev[2]),
        .debug_reset_event(ev[3]), .dbg_pin_stop_reset(ev[4]),
        .gpio_stop_recovery(ev[5]), .device_reset_req,
        .stop_recovery_req, .osc_run
    );

    function automatic logic [7:0] flags(input logic p, s, t, x, m);
        return {p, s, t, x, 3'h0, m};
    endfunction

    // Flags expected after one event from a cleared state
    function automatic logic [7:0] cause(input int i);
        case (i)
        2: return flags(0, 0, 0, 1, 0);
        5: return flags(0, 1, 0, 0, 0);
        default: return flags(1, 0, 0, 0, 0);
        endcase
    endfunction

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tmo(input logic ok);
        if (!ok) begin
            fails++;
            close_out();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v,
                      input logic s = 1'b1);
        int n;
        logic got;
        n = 0;
        got = 0;
        awaddr <= a;
        wdata <= {PAD_ZERO, v};
        wstrb <= {3'h0, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got && n < 40) begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            got = (bvalid === 1'b1);
        end
        rsp = bresp;
        bready <= 1'b0;
        tmo(got);
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a);
        int n;
        logic got;
        n = 0;
        got = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got && n < 40) begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1)
                arvalid <= 1'b0;
            got = (rvalid === 1'b1);
        end
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
        tmo(got);
        @(posedge aclk);
    endtask

    task automatic pulse(input int b);
        ev <= 6'h01 << b;
        @(posedge aclk);
        ev <= '0;
        @(posedge aclk);
    endtask

    task automatic unl;
        wr(OFF_STATUS_CONTROL, KEY_FIRST);
        wr(OFF_STATUS_CONTROL, KEY_SECOND);
    endtask

    task automatic load(input logic [23:0] v);
        unl();
        wr(OFF_RELOAD_UPPER, v[23:16]);
        wr(OFF_RELOAD_HIGH, v[15:8]);
        wr(OFF_RELOAD_LOW, v[7:0]);
    endtask

    task automatic cnt(input logic [23:0] e);
        logic [23:0] c;
        rd(OFF_RELOAD_UPPER);
        c[23:16] = d[7:0];
        rd(OFF_RELOAD_HIGH);
        c[15:8] = d[7:0];
        rd(OFF_RELOAD_LOW);
        c[7:0] = d[7:0];
        chk("count", {8'h00, c}, {8'h00, e});
    endtask

    task automatic stat(input logic [7:0] e);
        rd(OFF_STATUS_CONTROL);
        chk("status", d, {PAD_ZERO, e});
        chk("rresp", rsp, RESP_OKAY);
    endtask

    initial begin
        k = $urandom(32'hEF84);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        stat(flags(1, 0, 0, 0, 0));
        stat(8'h00);
        cnt(COUNT_RESET);
        for (int i = 2; i < 6; i++) begin
            pulse(i);
            stat(cause(i));
        end
        pulse(2);
        pulse(5);
        stat(flags(0, 1, 0, 0, 0));
        for (int i = 0; i < 3; i++) begin
            val = 24'($urandom()) | 24'h000010;
            load(val);
            stat(8'h00);
            if (i == 0)
                wr(OFF_WDT_CONTROL, 8'h03);
            else
                pulse(1);
            cnt(val);
            k = 1 + $urandom_range(4);
            repeat (k) pulse(0);
            cnt(val - 24'(k));
        end
        // Stray write between steps, then a full byte sequence
        for (int i = 0; i < 3; i++) begin
            unl();
            case (i)
            0: wr(OFF_WDT_CONTROL, 8'h03);
            1: wr(12'h100, 8'h00);
            default: wr(OFF_RELOAD_HIGH, 8'h00);
            endcase
            chk("bresp", rsp, (i == 1) ? RESP_SLVERR : RESP_OKAY);
            wr(OFF_RELOAD_UPPER, 8'h00);
            wr(OFF_RELOAD_HIGH, 8'h00);
            wr(OFF_RELOAD_LOW, 8'h01);
            pulse(1);
            cnt(val);
        end
        rd(OFF_WDT_CONTROL);
        chk("control", d, 32'h00000003);
        unl();
        wr(OFF_RELOAD_UPPER, 8'hFF, 1'b0);
        wr(OFF_RELOAD_UPPER, 8'h00);
        wr(OFF_RELOAD_HIGH, 8'h00);
        wr(OFF_RELOAD_LOW, 8'h02);
        pulse(1);
        cnt(24'h000002);
        pulse(5);
        repeat (3) pulse(0);
        stat(flags(0, 0, 1, 0, 0));
        chk("reset req", rst_seen, 1);
        unl();
        wr(OFF_STATUS_CONTROL, STOP_OFF_CODE);
        stat(flags(0, 0, 0, 0, 1));
        stop_mode <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("osc run", osc_run, 0);
        repeat (2) pulse(0);
        stop_mode <= 1'b0;
        cnt(24'h000002);
        unl();
        wr(OFF_STATUS_CONTROL, STOP_ON_CODE);
        stop_mode <= 1'b1;
        repeat (3) pulse(0);
        chk("osc run", osc_run, 1);
        stop_mode <= 1'b0;
        stat(flags(0, 1, 1, 0, 0));
        chk("stop recovery", smr_seen, 1);
        chk("reset req", rst_seen, 1);
        close_out();
    end
endmodule
